// File: dv/spiee_host_model.sv
// SPI host model for the serial EEPROM block, mode 0, MSB first.
// Assumes the bench calls one task at a time from a single process.
`timescale 1ns/100ps

module spiee_host_model (
  input wire mclk_i,
  input wire miso_i,
  input wire miso_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o
);
  logic last_q;
  wire miso_w;

  // ------
  // Line
  // ------
  // Released line reads as the inverse of the last bit, so stale data never matches
  assign miso_w = miso_oe_i ? miso_i : ~last_q;
  always @(posedge mclk_i) begin
    if (miso_oe_i) begin
      last_q <= miso_i;
    end
  end

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
    last_q = 1'b0;
  end

  // Select on the mclk edge by non-blocking assignment; clock stays low outside frames
  task automatic select;
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    #160;
  endtask

  // Data in set in low phase; data out taken at the end of the high phase
  task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      mosi_o <= tx[7 - i];
      #160;
      sclk_o <= 1'b1;
      #150;
      rx = {rx[6:0], miso_w};
      #10;
      sclk_o <= 1'b0;
    end
  endtask

  // Deselect in the low phase after the last bit; the long gap lets programming start
  task automatic deselect;
    #160;
    cs_n_o <= 1'b1;
    #1600;
  endtask
endmodule // spiee_host_model

// File: dv/spiee_top_sva.sv
// Port-level checker for the serial EEPROM block.
// Assumes it is bound into spiee_top and sees only its ports.
`timescale 1ns/100ps

module spiee_top_sva #(
  parameter int WRITE_CYCLES = 50
) (
  input wire mclk_i,
  input wire rst_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire mosi_i,
  input wire wp_n_i,
  input wire miso_o,
  input wire miso_oe_o,
  input wire write_busy_flag_o,
  input wire enable_latch_flag_o,
  input wire [1:0] protect_level_o
);
  logic [2:0] sclk_q;
  logic cs_q;
  logic [2:0] bits_q;
  int busy_cnt_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ------
  // Helpers
  // ------
  // Bit count mod 8 within a frame, kept after deselect for the start check
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q <= 3'h0;
      cs_q <= 1'b1;
      bits_q <= 3'h0;
      busy_cnt_q <= 0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk_i};
      cs_q <= cs_n_i;
      busy_cnt_q <= write_busy_flag_o ? busy_cnt_q + 1 : 0;
      if (cs_q && !cs_n_i) begin
        bits_q <= 3'h0;
      end else if (!cs_n_i && sclk_q[1] && !sclk_q[2]) begin
        bits_q <= bits_q + 3'h1;
      end
    end
  end

  property p_oe_idle; cs_n_i [*8] |-> !miso_oe_o; endproperty
  property p_wp_latch; !wp_n_i [*5] |-> !enable_latch_flag_o; endproperty
  property p_busy_start; $rose(write_busy_flag_o) |-> cs_n_i && wp_n_i && $past(enable_latch_flag_o); endproperty
  property p_busy_frame; $rose(write_busy_flag_o) |-> bits_q == 3'h0; endproperty
  property p_busy_min; $rose(write_busy_flag_o) |=> write_busy_flag_o [*8]; endproperty
  property p_busy_max; busy_cnt_q <= 2 * WRITE_CYCLES + 40; endproperty
  property p_end_latch; $fell(write_busy_flag_o) |-> !enable_latch_flag_o; endproperty
  property p_power_up; $fell(rst_i) |-> !enable_latch_flag_o && !write_busy_flag_o && !miso_oe_o; endproperty
  property p_latch_set; $rose(enable_latch_flag_o) |-> !cs_n_i && wp_n_i; endproperty
  property p_prot_change; $changed(protect_level_o) |-> $past(write_busy_flag_o); endproperty

  a_oe_idle: assert property (p_oe_idle) else $error("serial out driven while deselected");
  a_wp_latch: assert property (p_wp_latch) else $error("latch set under write protect");
  a_busy_start: assert property (p_busy_start) else $error("programming without valid start");
  a_busy_frame: assert property (p_busy_frame) else $error("programming after partial byte");
  a_busy_min: assert property (p_busy_min) else $error("busy flag too short");
  a_busy_max: assert property (p_busy_max) else $error("busy flag stuck high");
  a_end_latch: assert property (p_end_latch) else $error("latch kept after programming");
  a_power_up: assert property (p_power_up) else $error("wrong state after reset");
  a_latch_set: assert property (p_latch_set) else $error("latch set outside a frame");
  a_prot_change: assert property (p_prot_change) else $error("protect level changed off cycle");

  c_cycle_end: cover property ($fell(write_busy_flag_o));
  c_read_out: cover property ($rose(miso_oe_o));
  c_prot_set: cover property ($changed(protect_level_o));
endmodule // spiee_top_sva

bind spiee_top spiee_top_sva #(.WRITE_CYCLES(WRITE_CYCLES)) sva_u (.mclk_i(mclk_i), .rst_i(rst_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i), .wp_n_i(wp_n_i), .miso_o(miso_o),
  .miso_oe_o(miso_oe_o), .write_busy_flag_o(write_busy_flag_o),
  .enable_latch_flag_o(enable_latch_flag_o), .protect_level_o(protect_level_o));

// File: dv/tb_spiee_top.sv
// Self-checking bench for the serial EEPROM block.
// Assumes spiee_host_model as SPI host and a short programming time.
`timescale 1ns/100ps

module tb_spiee_top;
  localparam int WCYC = 2000;
  logic mclk_i;
  logic rst_i;
  logic wp_n_i;
  wire sclk, cs_n, mosi, miso, miso_oe, busy, latch;
  wire [1:0] prot;
  logic [7:0] rx;
  logic [7:0] exp_mem [0:1023];
  int fails;
  int comparisons;
  int cycles = 0;

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  spiee_top #(.WRITE_CYCLES(WCYC)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .wp_n_i(wp_n_i), .miso_o(miso), .miso_oe_o(miso_oe), .write_busy_flag_o(busy),
    .enable_latch_flag_o(latch), .protect_level_o(prot));
  spiee_host_model host_u (.mclk_i(mclk_i), .miso_i(miso), .miso_oe_i(miso_oe), .sclk_o(sclk),
    .cs_n_o(cs_n), .mosi_o(mosi));

  // ------
  // Tasks
  // ------
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic begin_cmd(input logic [7:0] c);
    host_u.select();
    host_u.shift(8, c, rx);
  endtask

  task automatic short_cmd(input logic [7:0] c);
    begin_cmd(c);
    host_u.deselect();
  endtask

  task automatic read_check(input logic [9:0] addr, input int n);
    logic [9:0] a;
    a = addr;
    begin_cmd({3'h0, addr[9:8], 3'h3});
    host_u.shift(8, addr[7:0], rx);
    for (int i = 0; i < n; i++) begin
      host_u.shift(8, 8'h00, rx);
      check8("array byte", exp_mem[a], rx);
      a = (a == 10'h1ff) ? 10'h000 : a + 10'h001;
    end
    check_bit("oe in read", 1'b1, miso_oe);
    host_u.deselect();
    check_bit("oe after read", 1'b0, miso_oe);
  endtask

  // Later bytes past offset f land back at offset 0 of the same page
  task automatic write_page(input logic [9:0] addr, input int n, input logic [7:0] d0, input logic ok);
    logic [9:0] a;
    short_cmd(8'h06);
    begin_cmd({3'h0, addr[9:8], 3'h2});
    host_u.shift(8, addr[7:0], rx);
    for (int i = 0; i < n; i++) begin
      host_u.shift(8, d0 + i[7:0], rx);
      a = addr;
      a[3:0] = addr[3:0] + i[3:0];
      if (ok) exp_mem[a] = d0 + i[7:0];
    end
    host_u.deselect();
    check_bit("busy after write", ok, busy);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (busy === 1'b1 && k < 4 * WCYC) begin
      @(posedge mclk_i);
      k++;
    end
    check_bit("busy ends", 1'b0, busy);
  endtask

  // Status read, then one more bit to see the wait state release the line
  task automatic flags_check(input logic [7:0] exp);
    begin_cmd(8'h05);
    host_u.shift(8, 8'h00, rx);
    check8("status byte", exp, rx);
    host_u.shift(1, 8'h00, rx);
    check_bit("oe after flags", 1'b0, miso_oe);
    host_u.deselect();
  endtask

  // Hang guard, well above the expected run of about 13500 cycles
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails = fails + 1;
      print_verdict();
    end
  end

  // ------
  // Tests
  // ------
  initial begin
    rst_i = 1'b1;
    wp_n_i = 1'b1;
    fails = 0;
    comparisons = 0;
    for (int i = 0; i < 1024; i++) exp_mem[i] = 8'hff;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    check_bit("latch at power-up", 1'b0, latch);
    check_bit("busy at power-up", 1'b0, busy);
    check_bit("oe idle", 1'b0, miso_oe);
    check8("protect at power-up", 8'h00, {6'h0, prot});
    flags_check(8'hf0);
    short_cmd(8'h1e);
    check_bit("latch set", 1'b1, latch);
    short_cmd(8'h1c);
    check_bit("latch cleared", 1'b0, latch);
    write_page(10'h1fe, 18, 8'h10, 1'b1);
    flags_check(8'hf3);
    begin_cmd(8'h03);
    host_u.shift(8, 8'h00, rx);
    host_u.shift(8, 8'h00, rx);
    check_bit("oe read while busy", 1'b0, miso_oe);
    host_u.deselect();
    wait_idle();
    check_bit("latch after cycle", 1'b0, latch);
    write_page(10'h000, 1, 8'h5a, 1'b1);
    wait_idle();
    read_check(10'h1fe, 4);
    // Write cut four bits into a data byte
    short_cmd(8'h06);
    begin_cmd(8'h02);
    host_u.shift(8, 8'h10, rx);
    host_u.shift(8, 8'h66, rx);
    host_u.shift(4, 8'h66, rx);
    host_u.deselect();
    check_bit("busy after cut write", 1'b0, busy);
    read_check(10'h010, 1);
    // Flags write protecting the top quarter
    short_cmd(8'h06);
    begin_cmd(8'h01);
    host_u.shift(8, 8'h04, rx);
    host_u.deselect();
    wait_idle();
    check8("protect level", 8'h01, {6'h0, prot});
    write_page(10'h300, 1, 8'h77, 1'b0);
    write_page(10'h2f0, 2, 8'h33, 1'b1);
    wait_idle();
    read_check(10'h2ff, 2);
    // Write protect pin held low
    short_cmd(8'h06);
    @(posedge mclk_i);
    wp_n_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    check_bit("latch under wp", 1'b0, latch);
    write_page(10'h020, 1, 8'h44, 1'b0);
    @(posedge mclk_i);
    wp_n_i <= 1'b1;
    // Unknown command leaves the line released
    begin_cmd(8'he3);
    host_u.shift(8, 8'h00, rx);
    check_bit("oe after bad command", 1'b0, miso_oe);
    host_u.deselect();
    read_check(10'h020, 1);
    print_verdict();
  end
endmodule // tb_spiee_top

// File: rtl/spiee_defs.vh
// Constants for the serial EEPROM array access block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SPIEE_DEFS_VH
`define SPIEE_DEFS_VH

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define SPIEE_ADDR_W 10
`define SPIEE_ARRAY_BYTES 1024
`define SPIEE_ERASED_BYTE 8'hff
`define SPIEE_READ_WRAP_TOP 10'h1ff
`define SPIEE_READ_WRAP_TO 10'h000
`define SPIEE_PAGE_OFS_W 4

// ----------------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------------
`define SPIEE_CMD_TOP 3'h0
`define SPIEE_CMD_SET_EN 3'h6
`define SPIEE_CMD_CLR_EN 3'h4
`define SPIEE_CMD_RD_FLAGS 3'h5
`define SPIEE_CMD_WR_FLAGS 3'h1
`define SPIEE_CMD_READ 3'h3
`define SPIEE_CMD_WRITE 3'h2

// ----------------------------------------------------------------------
// Status byte and protect levels
// ----------------------------------------------------------------------
`define SPIEE_STATUS_ONES 4'hf
`define SPIEE_PROT_NONE 2'h0
`define SPIEE_PROT_QUARTER 2'h1
`define SPIEE_PROT_HALF 2'h2
`define SPIEE_PROT_ALL 2'h3
`define SPIEE_PROT_QUARTER_BASE 10'h300
`define SPIEE_PROT_HALF_BASE 10'h200
`define SPIEE_PROT_RESET 2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SPIEE_LAST_BIT 3'h7
`define SPIEE_WRITE_TIME_MS 10
`define SPIEE_MCLK_KHZ 25000
`define SPIEE_WRITE_CYCLES (`SPIEE_WRITE_TIME_MS * `SPIEE_MCLK_KHZ)
`define SPIEE_TIMER_W 20

`endif

// File: rtl/spiee_fifo.v
// Small synchronous FIFO that holds page write bytes until programming.
// Assumes one clock, async active-high reset, and a flush from the owner.
`timescale 1ns/100ps

module spiee_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire mclk_i,
  input wire rst_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire push;
  wire pop;

  // --------------------------------------------------------------------
  // Status: the extra pointer bit tells full from empty
  // --------------------------------------------------------------------
  assign out_valid_o = (wr_q != rd_q);
  assign in_ready_o = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  // Storage has no reset; only pointers define content validity
  always @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers; flush drops everything pending
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // spiee_fifo

// File: rtl/spiee_top.v
// Serial EEPROM array access: SPI slave front end, array, flags, programming.
// Assumes SPI pins arrive asynchronously and are oversampled by mclk_i,
// with the serial clock at most an eighth of mclk_i.
`timescale 1ns/100ps
`include "spiee_defs.vh"

module spiee_top #(
  parameter WRITE_CYCLES = `SPIEE_WRITE_CYCLES,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire mclk_i,
  input wire rst_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire mosi_i,
  input wire wp_n_i,
  output reg miso_o,
  output reg miso_oe_o,
  output reg write_busy_flag_o,
  output reg enable_latch_flag_o,
  output reg [1:0] protect_level_o
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [6:0] ST_CMD = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_RDATA = 7'h04;
  localparam [6:0] ST_WDATA = 7'h08;
  localparam [6:0] ST_FDATA = 7'h10;
  localparam [6:0] ST_RFLAGS = 7'h20;
  localparam [6:0] ST_WAIT = 7'h40;
  localparam FW = `SPIEE_PAGE_OFS_W + 8;
  localparam [31:0] WRITE_LOAD = WRITE_CYCLES - 1;

  // Locked range per protect level
  function prot_hit;
    input [`SPIEE_ADDR_W-1:0] a;
    input [1:0] lvl;
    begin
      case (lvl)
        `SPIEE_PROT_NONE: prot_hit = 1'b0;
        `SPIEE_PROT_QUARTER: prot_hit = (a >= `SPIEE_PROT_QUARTER_BASE);
        `SPIEE_PROT_HALF: prot_hit = (a >= `SPIEE_PROT_HALF_BASE);
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  // Sequential read address with its wrap
  function [`SPIEE_ADDR_W-1:0] rd_next;
    input [`SPIEE_ADDR_W-1:0] a;
    begin
      if (a == `SPIEE_READ_WRAP_TOP) begin
        rd_next = `SPIEE_READ_WRAP_TO;
      end else begin
        rd_next = a + {{(`SPIEE_ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Input synchronisers and edge detect
  // --------------------------------------------------------------------
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg sclk_prev_q;
  reg cs_prev_q;
  wire sclk_s = sync2_q[0];
  wire cs_n_s = sync2_q[1];
  wire mosi_s = sync2_q[2];
  wire wp_n_s = sync2_q[3];
  wire sel = ~cs_n_s;
  wire rise = sclk_s & ~sclk_prev_q & sel;
  wire fall = ~sclk_s & sclk_prev_q & sel;
  wire cs_rise = cs_n_s & ~cs_prev_q;

  // Only the second stage is read by logic; reset matches idle pins
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 4'he;
      sync2_q <= 4'he;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sync1_q <= {wp_n_i, mosi_i, cs_n_i, sclk_i};
      sync2_q <= sync1_q;
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg [7:0] array_q [0:`SPIEE_ARRAY_BYTES-1];
  reg [1:0] prot_q;
  integer i;

  // Delivered contents; never touched by reset since it is nonvolatile
  initial begin
    for (i = 0; i < `SPIEE_ARRAY_BYTES; i = i + 1) begin
      array_q[i] = `SPIEE_ERASED_BYTE;
    end
    prot_q = `SPIEE_PROT_RESET;
  end

  // --------------------------------------------------------------------
  // Link side registers
  // --------------------------------------------------------------------
  reg [6:0] state_q;
  reg [2:0] bit_q;
  reg [6:0] shift_q;
  reg [7:0] tx_q;
  reg [`SPIEE_ADDR_W-1:0] addr_q;
  reg [1:0] hi_q;
  reg rd_mode_q;
  reg loaded_q;
  reg abort_q;
  reg [7:0] flags_new_q;
  reg wel_q;
  reg prog_q;
  reg prog_flags_q;
  reg [`SPIEE_ADDR_W-1:0] page_q;
  reg [`SPIEE_TIMER_W-1:0] timer_q;

  wire [7:0] in_byte = {shift_q, mosi_s};
  wire byte_done = rise && (bit_q == `SPIEE_LAST_BIT);
  wire [7:0] status = {`SPIEE_STATUS_ONES, prot_q, wel_q, prog_q};
  wire [`SPIEE_ADDR_W-1:0] rd_addr = {hi_q, in_byte};

  // FIFO wiring
  wire fifo_in_valid = (state_q == ST_WDATA) && byte_done;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire drain = prog_q && ~prog_flags_q;
  wire cs_valid_end = (bit_q == 3'h0) && loaded_q && ~abort_q;
  wire start_array = cs_rise && (state_q == ST_WDATA) && cs_valid_end && wel_q && wp_n_s
                     && ~prot_hit(page_q, prot_q);
  wire start_flags = cs_rise && (state_q == ST_FDATA) && cs_valid_end && wel_q && wp_n_s;
  wire fifo_flush = cs_rise && ~start_array && ~prog_q;
  wire timer_end = prog_q && (timer_q == {`SPIEE_TIMER_W{1'b0}});
  wire prog_done = timer_end && ~fifo_out_valid;

  spiee_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .flush_i(fifo_flush),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i({addr_q[`SPIEE_PAGE_OFS_W-1:0], in_byte}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(drain),
    .out_data_o(fifo_out_data)
  );

  // --------------------------------------------------------------------
  // Protocol engine
  // --------------------------------------------------------------------
  // Deselect returns to command decode; edges seen while deselected
  // never reach this process, so stray clocks change nothing
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_CMD;
      bit_q <= 3'h0;
      shift_q <= 7'h00;
      tx_q <= 8'hff;
      addr_q <= {`SPIEE_ADDR_W{1'b0}};
      hi_q <= 2'h0;
      rd_mode_q <= 1'b0;
      loaded_q <= 1'b0;
      abort_q <= 1'b0;
      flags_new_q <= 8'h00;
      page_q <= {`SPIEE_ADDR_W{1'b0}};
    end else if (cs_n_s) begin
      state_q <= ST_CMD;
      bit_q <= 3'h0;
      loaded_q <= 1'b0;
      abort_q <= 1'b0;
    end else if (rise) begin
      shift_q <= in_byte[6:0];
      bit_q <= bit_q + 3'h1;
      if (byte_done) begin
        case (state_q)
          ST_CMD: begin
            hi_q <= in_byte[4:3];
            if (in_byte[7:5] != `SPIEE_CMD_TOP) begin
              state_q <= ST_WAIT;
            end else begin
              case (in_byte[2:0])
                `SPIEE_CMD_SET_EN: state_q <= ST_WAIT;
                `SPIEE_CMD_CLR_EN: state_q <= ST_WAIT;
                `SPIEE_CMD_RD_FLAGS: begin
                  tx_q <= status;
                  state_q <= ST_RFLAGS;
                end
                `SPIEE_CMD_WR_FLAGS: state_q <= prog_q ? ST_WAIT : ST_FDATA;
                `SPIEE_CMD_READ: begin
                  rd_mode_q <= 1'b1;
                  state_q <= prog_q ? ST_WAIT : ST_ADDR;
                end
                `SPIEE_CMD_WRITE: begin
                  rd_mode_q <= 1'b0;
                  state_q <= prog_q ? ST_WAIT : ST_ADDR;
                end
                default: state_q <= ST_WAIT;
              endcase
            end
          end
          ST_ADDR: begin
            addr_q <= rd_addr;
            page_q <= rd_addr;
            if (rd_mode_q) begin
              tx_q <= array_q[rd_addr];
              state_q <= ST_RDATA;
            end else begin
              state_q <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            addr_q <= rd_next(addr_q);
            tx_q <= array_q[rd_next(addr_q)];
          end
          ST_WDATA: begin
            // Offset wraps inside the page; a full FIFO spoils the write
            addr_q[`SPIEE_PAGE_OFS_W-1:0] <= addr_q[`SPIEE_PAGE_OFS_W-1:0] + 4'h1;
            loaded_q <= 1'b1;
            if (!fifo_in_ready) begin
              abort_q <= 1'b1;
            end
          end
          ST_FDATA: begin
            flags_new_q <= in_byte;
            abort_q <= loaded_q; // A second byte voids the status write
            loaded_q <= 1'b1;
          end
          ST_RFLAGS: state_q <= ST_WAIT;
          ST_WAIT: state_q <= ST_WAIT;
          default: state_q <= ST_WAIT;
        endcase
      end
    end else if (fall && (state_q == ST_RDATA || state_q == ST_RFLAGS)) begin
      tx_q <= {tx_q[6:0], 1'b1};
    end
  end

  // --------------------------------------------------------------------
  // Serial out and its enable
  // --------------------------------------------------------------------
  // Data changes on the falling edge so the host samples a stable bit
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      miso_o <= 1'b1;
      miso_oe_o <= 1'b0;
    end else if (cs_n_s) begin
      miso_oe_o <= 1'b0;
    end else if (fall && (state_q == ST_RDATA || state_q == ST_RFLAGS)) begin
      miso_o <= tx_q[7];
      miso_oe_o <= 1'b1;
    end else if (state_q != ST_RDATA && state_q != ST_RFLAGS) begin
      miso_oe_o <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Enable latch
  // --------------------------------------------------------------------
  // The set only lands at command end; the clears win where they meet
  // because each clear reflects a condition that forbids writing
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wel_q <= 1'b0;
    end else if (!wp_n_s || prog_done) begin
      wel_q <= 1'b0;
    end else if (byte_done && state_q == ST_CMD && in_byte[7:5] == `SPIEE_CMD_TOP) begin
      if (in_byte[2:0] == `SPIEE_CMD_SET_EN) begin
        wel_q <= 1'b1;
      end else if (in_byte[2:0] == `SPIEE_CMD_CLR_EN) begin
        wel_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Programming cycle
  // --------------------------------------------------------------------
  // Timer holds busy; the FIFO drains into the page during the cycle,
  // and the cycle cannot end while bytes are still pending
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_q <= 1'b0;
      prog_flags_q <= 1'b0;
      timer_q <= {`SPIEE_TIMER_W{1'b0}};
    end else if (!prog_q && (start_array || start_flags)) begin
      prog_q <= 1'b1;
      prog_flags_q <= start_flags;
      timer_q <= WRITE_LOAD[`SPIEE_TIMER_W-1:0];
    end else if (prog_done) begin
      prog_q <= 1'b0;
      prog_flags_q <= 1'b0;
    end else if (prog_q && !timer_end) begin
      timer_q <= timer_q - {{(`SPIEE_TIMER_W-1){1'b0}}, 1'b1};
    end
  end

  // Array update, one queued byte per clock; page base stays fixed
  always @(posedge mclk_i) begin
    if (drain && fifo_out_valid) begin
      array_q[{page_q[`SPIEE_ADDR_W-1:`SPIEE_PAGE_OFS_W], fifo_out_data[FW-1:8]}] <=
        fifo_out_data[7:0];
    end
  end

  // Protect bits change only at the end of a status write cycle
  always @(posedge mclk_i) begin
    if (prog_done && prog_flags_q) begin
      prot_q <= flags_new_q[3:2];
    end
  end

  // --------------------------------------------------------------------
  // Flag outputs
  // --------------------------------------------------------------------
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      write_busy_flag_o <= 1'b0;
      enable_latch_flag_o <= 1'b0;
      protect_level_o <= `SPIEE_PROT_RESET;
    end else begin
      write_busy_flag_o <= prog_q;
      enable_latch_flag_o <= wel_q;
      protect_level_o <= prot_q;
    end
  end

endmodule // spiee_top
